// ==== rtl/adccrc_pkg.sv ====
// constants and carrier types for the conversion start and readout block
// assumes one 200 MHz clock and a classic wishbone slave for registers
//
// What this block does
// - start conversion only when byte select, chip select and read all low
// - ignore further starts until the running conversion finishes
// - conversion active output low during conversion, high otherwise
// - pipelined mode read that starts conversion returns previous result
// - result right justified in a 16-bit word, lsb rightmost
// - byte select low gives bits 7..0, high gives top four on lowest lines
// - upper nibble outputs always carry result bits 11..8 while driving
// - wait-state read start takes active low and drives previous result meanwhile
// - at end, update latches and outputs on the same edge that releases active output
// - read with byte select high starts nothing, returns top bits on lines 3..0 and 11..8, lines 7..4 low
// - pipelined second read returns fresh result and starts the next conversion
// - pipelined third low byte read returns new low byte and starts next
// - conversion completes within 6.0 us, no external clock needed
package adccrc_pkg;
	localparam int CONV_TIME_NS = 6000;
	localparam int CLK_PERIOD_NS = 5;
	// longest time rounds down
	localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam logic [3:0] ADR_CTRL = 4'h0;
	localparam logic [3:0] ADR_STATUS = 4'h4;
	localparam logic [3:0] ADR_IRQ_STAT = 4'h8;
	localparam logic [3:0] ADR_IRQ_MASK = 4'hC;
	localparam logic [11:0] RESULT_RESET = 12'h000;
	localparam logic [1:0] IRQ_RESET = 2'h0;
	// host strobes as sampled; chip select and read active low, byte select high picks the top bits
	typedef struct packed {
		logic byteSelectHigh;
		logic chipSelN;
		logic readN;
	} adccrc_strobe_t;
	// data pins with per-pin enable
	typedef struct packed {
		logic [11:0] data;
		logic [11:0] dataOe;
	} adccrc_dout_t;
endpackage

// ==== rtl/adccrc_top.sv ====
// conversion start, busy and result readout of a 12-bit sampling converter
// assumes async host strobes on pins, a sample word from the analog core,
// and a wishbone classic register bus on clk
//
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module adccrc_top #(
	parameter int CONV_CYCLES = adccrc_pkg::CONV_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        byteSelectHigh,
	input  wire logic        chipSelN,
	input  wire logic        readN,
	input  wire logic [11:0] sampleIn,
	output logic      [11:0] upperNibbleOutputs,
	output logic      [11:0] dataOe,
	output logic             convActiveN,
	output logic             irq,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_we_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o
);
	// ********************************************
	// pin synchronisers
	// ********************************************
	adccrc_pkg::adccrc_strobe_t s1Reg, s2Reg, s3Reg;
	// three stages; a level counts once stage two and three agree
	always_ff @(posedge clk) begin
		if (rst) begin
			s1Reg <= 3'h7;
			s2Reg <= 3'h7;
			s3Reg <= 3'h7;
		end else begin
			s1Reg <= {byteSelectHigh, chipSelN, readN};
			s2Reg <= s1Reg;
			s3Reg <= s2Reg;
		end
	end
	adccrc_pkg::adccrc_strobe_t pinReg;
	always_ff @(posedge clk) begin
		if (rst) begin
			pinReg <= 3'h7;
		end else begin
			if (s2Reg.byteSelectHigh == s3Reg.byteSelectHigh) begin
				pinReg.byteSelectHigh <= s3Reg.byteSelectHigh;
			end
			if (s2Reg.chipSelN == s3Reg.chipSelN) begin
				pinReg.chipSelN <= s3Reg.chipSelN;
			end
			if (s2Reg.readN == s3Reg.readN) begin
				pinReg.readN <= s3Reg.readN;
			end
		end
	end

	// ********************************************
	// registers
	// ********************************************
	logic        pipeModeReg;      // 1 selects pipelined reads
	logic [1:0]  irqStatReg;       // bit0 conversion done, bit1 start ignored
	logic [1:0]  irqMaskReg;
	logic [11:0] resultReg;
	logic [15:0] convCountReg;
	logic        convBusyReg;
	logic        readActiveReg;

	wire logic readSel = !pinReg.chipSelN && !pinReg.readN;
	wire logic startCond = readSel && !pinReg.byteSelectHigh;
	wire logic startEdge = startCond && !readActiveReg;

	// track access so one read starts at most one conversion
	always_ff @(posedge clk) begin
		if (rst) begin
			readActiveReg <= 1'b0;
		end else begin
			readActiveReg <= startCond;
		end
	end

	// ********************************************
	// conversion engine
	// ********************************************
	wire logic convDone = convBusyReg && (convCountReg == 16'(CONV_CYCLES - 1));
	always_ff @(posedge clk) begin
		if (rst) begin
			convBusyReg <= 1'b0;
			convCountReg <= 16'h0000;
		end else if (convBusyReg) begin
			convCountReg <= convCountReg + 16'h0001;
			if (convDone) begin
				convBusyReg <= 1'b0;
			end
		end else if (startEdge) begin
			convBusyReg <= 1'b1;
			convCountReg <= 16'h0000;
		end
	end

	// latch result at end, busy clears the same edge so data and busy change together
	always_ff @(posedge clk) begin
		if (rst) begin
			resultReg <= adccrc_pkg::RESULT_RESET;
		end else if (convDone) begin
			resultReg <= sampleIn;
		end
	end
	// next latch value, so the pins take the new word on the same edge
	// that ends the conversion instead of one edge after busy rises
	wire logic [11:0] resultNext = convDone ? sampleIn : resultReg;

	assign convActiveN = !convBusyReg;

	// ********************************************
	// data outputs
	// ********************************************
	// wait-state mode keeps previous data until latch update, pipelined likewise
	// returns the previous result at start; both read the same latch, so the
	// mode bit changes nothing in the data path and is only read back over the bus
	always_ff @(posedge clk) begin
		if (rst) begin
			upperNibbleOutputs <= 12'h000;
			dataOe <= 12'h000;
		end else begin
			dataOe <= readSel ? 12'hFFF : 12'h000;
			// top nibble always on upper lines
			upperNibbleOutputs[11:8] <= resultNext[11:8];
			if (pinReg.byteSelectHigh) begin
				upperNibbleOutputs[7:0] <= {4'h0, resultNext[11:8]};
			end else begin
				upperNibbleOutputs[7:0] <= resultNext[7:0];
			end
		end
	end

	// ********************************************
	// interrupts and wishbone slave
	// ********************************************
	wire logic wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// a write commits at the edge where the master sees ack high,
	// not one cycle early while the request is still unanswered
	wire logic wbWr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
	wire logic startIgnored = startEdge && convBusyReg;

	always_ff @(posedge clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wbReq;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pipeModeReg <= 1'b0;
			irqMaskReg <= adccrc_pkg::IRQ_RESET;
		end else if (wbWr && wb_adr_i == adccrc_pkg::ADR_CTRL) begin
			pipeModeReg <= wb_dat_i[0];
		end else if (wbWr && wb_adr_i == adccrc_pkg::ADR_IRQ_MASK) begin
			irqMaskReg <= wb_dat_i[1:0];
		end
	end

	// write one clears; a set in the same cycle wins
	always_ff @(posedge clk) begin
		if (rst) begin
			irqStatReg <= adccrc_pkg::IRQ_RESET;
		end else begin
			irqStatReg <= (irqStatReg
				& ~((wbWr && wb_adr_i == adccrc_pkg::ADR_IRQ_STAT) ? wb_dat_i[1:0] : 2'h0))
				| {startIgnored, convDone};
		end
	end

	assign irq = |(irqStatReg & irqMaskReg);

	always_ff @(posedge clk) begin
		if (rst) begin
			wb_dat_o <= 32'h0000_0000;
		end else begin
			case (wb_adr_i)
				adccrc_pkg::ADR_CTRL:     wb_dat_o <= {31'h0, pipeModeReg};
				adccrc_pkg::ADR_STATUS:   wb_dat_o <= {19'h0, convBusyReg, resultReg};
				adccrc_pkg::ADR_IRQ_STAT: wb_dat_o <= {30'h0, irqStatReg};
				adccrc_pkg::ADR_IRQ_MASK: wb_dat_o <= {30'h0, irqMaskReg};
				default:                  wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// ********************************************
	// checks
	// ********************************************
	// the checks watch the synced strobe view, the engine and the pins; they
	// never look at the raw pins, whose timing belongs to the host

	// helper age counter for the conversion bound: a delay range spanning a
	// whole conversion at the full clock rate would be far too long to unroll,
	// so the length is carried in this counter and the check compares against it
	logic [15:0] busyAgeReg;
	always_ff @(posedge clk) begin
		if (rst) begin
			busyAgeReg <= 16'h0000;
		end else if (convBusyReg) begin
			// saturate so a stuck engine keeps the check firing instead of wrapping
			if (busyAgeReg != 16'hFFFF) begin
				busyAgeReg <= busyAgeReg + 16'h0001;
			end
		end else begin
			busyAgeReg <= 16'h0000;
		end
	end

	// a start that the engine accepts: strobes newly low while idle
	sequence seqStart;
		startEdge && !convBusyReg;
	endsequence
	// a start that lands on a running conversion and must be dropped
	sequence seqLateStart;
		startEdge && convBusyReg;
	endsequence
	// the last cycle of a conversion, when the sample is taken
	sequence seqEnd;
		convDone;
	endsequence
	// a low byte or full word read seen through the synchronisers
	sequence seqLowRead;
		readSel && !pinReg.byteSelectHigh;
	endsequence
	// a high byte read seen through the synchronisers
	sequence seqHighRead;
		readSel && pinReg.byteSelectHigh;
	endsequence

	property pConvLen;
		@(posedge clk) disable iff (rst)
			seqStart |=> (!convActiveN)[*8];
	endproperty
	AST_BUSY_HOLD: assert property (pConvLen) else $error("busy dropped early");

	property pStartAnswer;
		@(posedge clk) disable iff (rst)
			seqStart |=> !convActiveN && convCountReg == 16'h0000;
	endproperty
	AST_START_ANSWER: assert property (pStartAnswer) else $error("start not answered");

	AST_START_GATE: assert property (
		@(posedge clk) disable iff (rst)
		$rose(convBusyReg) |-> $past(startEdge)
	) else $error("start without strobes");

	AST_NO_HIGH_START: assert property (
		@(posedge clk) disable iff (rst)
		pinReg.byteSelectHigh && !convBusyReg |=> !convBusyReg
	) else $error("high byte started");

	AST_NO_RESTART: assert property (
		@(posedge clk) disable iff (rst)
		convBusyReg && !convDone |=> convCountReg == $past(convCountReg) + 16'h0001
	) else $error("restart while busy");

	AST_LATE_DROP: assert property (
		@(posedge clk) disable iff (rst)
		seqLateStart ##0 !convDone |=> irqStatReg[1] && !convActiveN
	) else $error("late start not dropped");

	AST_LATCH_FIRST: assert property (
		@(posedge clk) disable iff (rst)
		seqEnd |=> resultReg == $past(sampleIn) && convActiveN
	) else $error("latch order");

	// pins carry the new word as busy rises
	AST_DATA_AT_END: assert property (
		@(posedge clk) disable iff (rst)
		seqEnd ##0 seqLowRead |=> upperNibbleOutputs == $past(sampleIn) && convActiveN
	) else $error("data after busy");

	AST_DONE_FLAG: assert property (
		@(posedge clk) disable iff (rst)
		seqEnd |=> irqStatReg[0]
	) else $error("done flag missing");

	AST_HIZ: assert property (
		@(posedge clk) disable iff (rst)
		!readSel |=> dataOe == 12'h000
	) else $error("driving while idle");

	AST_OE_ON: assert property (
		@(posedge clk) disable iff (rst)
		readSel |=> dataOe == 12'hFFF
	) else $error("not driving in read");

	AST_NIBBLE: assert property (
		@(posedge clk) disable iff (rst)
		1'b1 |=> upperNibbleOutputs[11:8] == resultReg[11:8]
	) else $error("nibble");

	AST_LOW_BYTE: assert property (
		@(posedge clk) disable iff (rst)
		!pinReg.byteSelectHigh |=> upperNibbleOutputs[7:0] == resultReg[7:0]
	) else $error("low byte");

	// high byte on lowest lines, lines 7..4 low
	AST_HIGH_BYTE: assert property (
		@(posedge clk) disable iff (rst)
		seqHighRead |=> upperNibbleOutputs[7:0] == {4'h0, resultReg[11:8]}
	) else $error("high byte");

	AST_MAX_TIME: assert property (
		@(posedge clk) disable iff (rst)
		convBusyReg |-> busyAgeReg < 16'(CONV_CYCLES)
	) else $error("conversion too long");

	// wishbone ack is a one cycle pulse
	AST_ACK_PULSE: assert property (
		@(posedge clk) disable iff (rst)
		wb_ack_o |=> !wb_ack_o
	) else $error("ack held");
endmodule
`default_nettype wire

// ==== verif/adccrc_host_model.sv ====
// host model: drives the three read strobes and derives the stall acknowledge
// assumes the bench calls press and lift from its clocked sequence
`timescale 1ns/1ps
`default_nettype none
module adccrc_host_model (
	input  wire logic clk,
	input  wire logic convActiveN,
	output logic      byteSelectHigh,
	output logic      chipSelN,
	output logic      readN,
	output logic      hostTransferAckN
);
	// ********
	// strobes
	// ********
	// idle: deselected, no read
	initial begin
		{byteSelectHigh, chipSelN, readN} = 3'h7;
	end
	// stall glue
	// withheld while selected and converting, so a waiting host cannot grab stale data
	assign hostTransferAckN = chipSelN | ~convActiveN;
	task automatic press(input logic bsh);
		@(posedge clk);
		{byteSelectHigh, chipSelN, readN} <= {bsh, 2'h0};
	endtask
	task automatic lift();
		@(posedge clk);
		{byteSelectHigh, chipSelN, readN} <= 3'h7;
	endtask
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// bench for the conversion start and readout block
// assumes the host model on the strobes and a wishbone master in here
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int CV = 40;
	logic             clk;
	logic             rst;
	logic      [11:0] sampleIn;
	logic      [3:0]  wbAdr;
	logic      [31:0] wbDatW;
	logic             wbWe;
	logic             wbCyc;
	logic      [31:0] rd;
	logic      [11:0] seen;
	logic      [11:0] busySeen;
	int               errors;
	int               compares;
	int               busyCnt;
	int               n;
	wire logic        bsh, csN, rdN, ackN, convActiveN, irq, wbAck;
	wire logic [11:0] dout;
	wire logic [11:0] dataOe;
	wire logic [31:0] wbDatR;
	adccrc_top #(.CONV_CYCLES(CV)) dut (.clk(clk), .rst(rst), .byteSelectHigh(bsh),
		.chipSelN(csN), .readN(rdN), .sampleIn(sampleIn), .upperNibbleOutputs(dout),
		.dataOe(dataOe), .convActiveN(convActiveN), .irq(irq), .wb_adr_i(wbAdr),
		.wb_dat_i(wbDatW), .wb_sel_i(4'hF), .wb_we_i(wbWe), .wb_cyc_i(wbCyc),
		.wb_stb_i(wbCyc), .wb_dat_o(wbDatR), .wb_ack_o(wbAck));
	adccrc_host_model host (.clk(clk), .convActiveN(convActiveN), .byteSelectHigh(bsh),
		.chipSelN(csN), .readN(rdN), .hostTransferAckN(ackN));
	// ********
	// helpers
	// ********
	task automatic test_done();
		if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// counts edges until busy shows lvl; a hang ends the run
	task automatic waitBusy(input logic lvl, output int k);
		k = 0;
		while (convActiveN !== lvl && k < 300) begin
			@(posedge clk);
			k++;
		end
		if (k == 300) begin
			errors++;
			test_done();
		end
	endtask
	// one classic cycle held until ack is sampled, then a few idle edges
	task automatic wb(input logic [3:0] a, input logic we, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		{wbCyc, wbWe, wbAdr, wbDatW} <= {1'h1, we, a, d};
		do begin
			@(posedge clk);
			k++;
		end while (wbAck !== 1'b1 && k < 20);
		if (k == 20) begin
			errors++;
			test_done();
		end
		rd = wbDatR;
		wbCyc <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic idle();
		waitBusy(1'b1, n);
		repeat (200) @(posedge clk);
	endtask
	// one host read; wt holds it through the conversion like a stalled host
	task automatic access(input logic b, input logic wt);
		host.press(b);
		if (wt) begin
			waitBusy(1'b0, n);
			@(posedge clk);
			busySeen = dout;
			waitBusy(1'b1, busyCnt);
			check("ack", ackN, 1'b0);
		end
		repeat (wt ? 2 : 8) @(posedge clk);
		seen = dout;
		check("oe on", dataOe, 12'hFFF);
		host.lift();
		repeat (6) @(posedge clk);
		check("oe off", dataOe, 12'h000);
	endtask
	// ********
	// scenarios
	// ********
	task automatic tWaitRead();
		wb(adccrc_pkg::ADR_CTRL, 1'b1, 32'h0);
		access(1'b0, 1'b1);
		check("old data", busySeen, 12'h000);
		check("busy len", busyCnt + 1, CV);
		check("new data", seen, 12'hA5C);
		access(1'b1, 1'b0);
		check("no start", convActiveN, 1'b1);
		check("high byte", seen, 12'hA0A);
	endtask
	task automatic tPipe();
		wb(adccrc_pkg::ADR_CTRL, 1'b1, 32'h1);
		sampleIn <= 12'h3E1;
		idle();
		access(1'b0, 1'b0);
		check("prev result", seen, 12'hA5C);
		idle();
		access(1'b1, 1'b0);
		check("new high", seen, 12'h303);
		sampleIn <= 12'h7B2;
		access(1'b0, 1'b0);
		check("fresh result", seen, 12'h3E1);
		check("next start", convActiveN, 1'b0);
		idle();
	endtask
	// a second start inside a conversion must neither restart nor extend it
	task automatic tRestart();
		wb(adccrc_pkg::ADR_IRQ_STAT, 1'b1, 32'h3);
		wb(adccrc_pkg::ADR_IRQ_MASK, 1'b1, 32'h3);
		check("irq idle", irq, 1'b0);
		host.press(1'b0);
		waitBusy(1'b0, n);
		host.lift();
		repeat (4) @(posedge clk);
		host.press(1'b0);
		repeat (4) @(posedge clk);
		host.lift();
		waitBusy(1'b1, busyCnt);
		check("busy len", busyCnt + 11, CV);
		repeat (10) @(posedge clk);
		check("no late start", convActiveN, 1'b1);
		wb(adccrc_pkg::ADR_IRQ_STAT, 1'b0, 32'h0);
		check("irq status", rd, 32'h3);
		check("irq on", irq, 1'b1);
		wb(adccrc_pkg::ADR_IRQ_MASK, 1'b1, 32'h0);
		check("irq masked", irq, 1'b0);
		wb(adccrc_pkg::ADR_IRQ_MASK, 1'b1, 32'h3);
		wb(adccrc_pkg::ADR_IRQ_STAT, 1'b1, 32'h3);
		check("irq cleared", irq, 1'b0);
		wb(adccrc_pkg::ADR_STATUS, 1'b0, 32'h0);
		check("status", rd, 32'h7B2);
		wb(4'h1, 1'b1, 32'hFFFF);
		wb(4'h1, 1'b0, 32'h0);
		check("unmapped", rd, 32'h0);
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		errors = 0;
		compares = 0;
		rst = 1'b1;
		sampleIn = 12'hA5C;
		{wbCyc, wbWe, wbAdr, wbDatW} = '0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		check("reset busy", convActiveN, 1'b1);
		check("reset oe", dataOe, 12'h000);
		tWaitRead();
		tPipe();
		tRestart();
		test_done();
	end
endmodule
`default_nettype wire
